// ==== rtl/cadm_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module cadm_core (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire cadm_pkg::cadm_mode_e addrMode,
  input wire logic addrStep,
  input wire logic [7:0] opByte1,
  input wire logic [7:0] opByte2,
  input wire logic [7:0] indexHigh,
  input wire logic [7:0] indexLow,
  input wire logic [15:0] stackPointer,
  input wire logic [1:0] baseCycles,
  output logic [15:0] srcAddr,
  output logic [15:0] dstAddr,
  output logic [7:0] immData,
  output logic [15:0] indexNext,
  output logic indexUpdate,
  output logic [2:0] busCycles,
  input wire logic waitOp,
  input wire logic stopOp,
  input wire logic haltOp,
  input wire logic breakpointHit,
  input wire logic irqPending,
  input wire logic debugPin,
  input wire logic hostAttached,
  input wire logic debugEnableSet,
  input wire logic minClocksInStop,
  input wire logic periodicWake,
  input wire logic cmdValid,
  input wire cadm_pkg::cadm_cmd_e cmdKind,
  output logic cmdAccept,
  output logic cmdExecute,
  output logic cmdError,
  output logic [7:0] cmdErrorCode,
  output logic clearIntMask,
  output logic cpuClockOn,
  output logic oscRun,
  output logic minClockRun,
  output logic inBackground,
  output logic debugEnable
);

  typedef enum logic [1:0] {RUN, WAITING, STOPPED, BACKGROUND} cadm_state_e;

  cadm_state_e state_r;
  cadm_state_e state_nxt;
  logic pinMeta_r;
  logic pinSync_r;
  logic inReset_r;
  logic debugEn_r;
  logic [15:0] indexPair;
  logic [15:0] word12;
  logic isHalt;
  logic isActiveCmd;
  logic isNonIntrusive;

  assign indexPair = {indexHigh, indexLow};
  assign word12 = {opByte1, opByte2};

  always_comb begin
    srcAddr = 16'h0000;
    dstAddr = 16'h0000;
    immData = 8'h00;
    indexUpdate = 1'b0;
    busCycles = {1'b0, baseCycles};
    unique case (addrMode)
      cadm_pkg::MODE_NONE: begin
      end
      cadm_pkg::MODE_IXW: begin
        srcAddr = 16'(indexPair + word12);
      end
      cadm_pkg::MODE_SPB: begin
        srcAddr = 16'(stackPointer + {8'h00, opByte1});
        busCycles = 3'(baseCycles + cadm_pkg::STACK_PREBYTE_CYCLES);
      end
      cadm_pkg::MODE_SPW: begin
        srcAddr = 16'(stackPointer + word12);
        busCycles = 3'(baseCycles + cadm_pkg::STACK_PREBYTE_CYCLES);
      end
      cadm_pkg::MODE_DD: begin
        srcAddr = {cadm_pkg::DIRECT_PAGE_HI, opByte1};
        dstAddr = {cadm_pkg::DIRECT_PAGE_HI, opByte2};
      end
      cadm_pkg::MODE_ID: begin
        immData = opByte1;
        dstAddr = {cadm_pkg::DIRECT_PAGE_HI, opByte2};
      end
      cadm_pkg::MODE_XD: begin
        srcAddr = indexPair;
        dstAddr = {cadm_pkg::DIRECT_PAGE_HI, opByte1};
        indexUpdate = addrStep;
      end
      cadm_pkg::MODE_DX: begin
        srcAddr = {cadm_pkg::DIRECT_PAGE_HI, opByte1};
        dstAddr = indexPair;
        indexUpdate = addrStep;
      end
    endcase
  end

  // addrStep marks the source read (XD) or the write (DX); the bump follows it
  assign indexNext = 16'(indexPair + cadm_pkg::ONE16);

  // Debug pin is asynchronous to the core clock
  always_ff @(posedge sys_clk) begin
    pinMeta_r <= debugPin;
    pinSync_r <= pinMeta_r;
  end

  always_ff @(posedge sys_clk) begin
    inReset_r <= sys_rst;
  end

  assign isHalt = cmdValid && cmdKind == cadm_pkg::CMD_HALT;
  assign isActiveCmd = cmdKind == cadm_pkg::CMD_CPUREG || cmdKind == cadm_pkg::CMD_STEP
    || cmdKind == cadm_pkg::CMD_RESUME;
  assign isNonIntrusive = !isActiveCmd && cmdKind != cadm_pkg::CMD_NONE;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RUN: begin
        if (isHalt || haltOp || breakpointHit) begin
          state_nxt = BACKGROUND;
        end else if (waitOp) begin
          state_nxt = WAITING;
        end else if (stopOp) begin
          state_nxt = STOPPED;
        end
      end
      WAITING: begin
        if (isHalt) begin
          state_nxt = BACKGROUND;
        end else if (irqPending) begin
          state_nxt = RUN;
        end
      end
      STOPPED: begin
        if (isHalt && debugEn_r) begin
          state_nxt = BACKGROUND;
        end else if (irqPending || (minClocksInStop && periodicWake)) begin
          state_nxt = RUN;
        end
      end
      BACKGROUND: begin
        if (cmdValid && (cmdKind == cadm_pkg::CMD_RESUME || cmdKind == cadm_pkg::CMD_STEP)) begin
          state_nxt = RUN;
        end
      end
    endcase
  end

  // Pin is sampled on the first cycle after reset release
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= RUN;
    end else if (inReset_r && !pinSync_r) begin
      state_r <= BACKGROUND;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      debugEn_r <= 1'b0;
    end else if (inReset_r && !pinSync_r) begin
      debugEn_r <= 1'b1;
    end else if (debugEnableSet) begin
      debugEn_r <= 1'b1;
    end
  end

  always_comb begin
    cmdAccept = 1'b0;
    cmdExecute = 1'b0;
    cmdError = 1'b0;
    cmdErrorCode = 8'h00;
    if (cmdValid) begin
      unique case (state_r)
        WAITING, STOPPED: begin
          if (isHalt && (state_r == WAITING || debugEn_r)) begin
            cmdAccept = 1'b1;
            cmdExecute = 1'b1;
          end else if (cmdKind == cadm_pkg::CMD_MEMSTAT) begin
            cmdAccept = 1'b1;
            cmdError = 1'b1;
            cmdErrorCode = cadm_pkg::ERR_STOP_WAIT;
          end
        end
        RUN: begin
          cmdAccept = isNonIntrusive;
          cmdExecute = isNonIntrusive;
        end
        BACKGROUND: begin
          cmdAccept = cmdKind != cadm_pkg::CMD_NONE;
          cmdExecute = cmdKind != cadm_pkg::CMD_NONE;
        end
      endcase
    end
  end

  assign clearIntMask = state_r == RUN && waitOp;
  assign cpuClockOn = state_r == RUN || state_r == BACKGROUND;
  assign oscRun = state_r != STOPPED || (debugEn_r && hostAttached);
  assign minClockRun = state_r != STOPPED || minClocksInStop;
  assign inBackground = state_r == BACKGROUND;
  assign debugEnable = debugEn_r;

  property p_spExtra;
    @(posedge sys_clk) disable iff (sys_rst)
    (addrMode == cadm_pkg::MODE_SPB || addrMode == cadm_pkg::MODE_SPW)
      |-> busCycles == 3'(baseCycles + 2'd1);
  endproperty
  a_spExtra: assert property (p_spExtra) else $error("stack mode cycle count wrong");

  property p_ixWord;
    @(posedge sys_clk) disable iff (sys_rst)
    addrMode == cadm_pkg::MODE_IXW |-> srcAddr == 16'({indexHigh, indexLow} + {opByte1, opByte2});
  endproperty
  a_ixWord: assert property (p_ixWord) else $error("indexed word address wrong");

  property p_spb;
    @(posedge sys_clk) disable iff (sys_rst)
    addrMode == cadm_pkg::MODE_SPB |-> srcAddr == 16'(stackPointer + {8'h00, opByte1});
  endproperty
  a_spb: assert property (p_spb) else $error("stack byte address wrong");

  property p_waitMask;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r == RUN && waitOp && !haltOp && !breakpointHit && !isHalt)
      |-> clearIntMask ##1 !cpuClockOn;
  endproperty
  a_waitMask: assert property (p_waitMask) else $error("wait did not gate clocks");

  sequence s_waitHalt;
    state_r == WAITING && isHalt;
  endsequence
  property p_waitHalt;
    @(posedge sys_clk) disable iff (sys_rst)
    s_waitHalt |-> cmdAccept ##1 (inBackground && cpuClockOn);
  endproperty
  a_waitHalt: assert property (p_waitHalt) else $error("halt in wait ignored");

  property p_waitErr;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r == WAITING && cmdValid && cmdKind == cadm_pkg::CMD_MEM) |-> !cmdAccept;
  endproperty
  a_waitErr: assert property (p_waitErr) else $error("memory command taken in wait");

  property p_oscKeep;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r == STOPPED && debugEn_r && hostAttached) |-> oscRun;
  endproperty
  a_oscKeep: assert property (p_oscKeep) else $error("oscillator stopped under debug");

  property p_activeOnly;
    @(posedge sys_clk) disable iff (sys_rst)
    (cmdValid && isActiveCmd && state_r != BACKGROUND) |-> !cmdExecute;
  endproperty
  a_activeOnly: assert property (p_activeOnly) else $error("active command run outside bg");

  property p_bgHold;
    @(posedge sys_clk) disable iff (sys_rst)
    (inBackground && !(cmdValid && (cmdKind == cadm_pkg::CMD_RESUME
      || cmdKind == cadm_pkg::CMD_STEP))) |=> inBackground;
  endproperty
  a_bgHold: assert property (p_bgHold) else $error("left background unasked");

  property p_spWord;
    @(posedge sys_clk) disable iff (sys_rst)
    addrMode == cadm_pkg::MODE_SPW |-> srcAddr == 16'(stackPointer + {opByte1, opByte2});
  endproperty
  a_spWord: assert property (p_spWord) else $error("stack word address wrong");

  property p_dirDir;
    @(posedge sys_clk) disable iff (sys_rst)
    addrMode == cadm_pkg::MODE_DD |-> srcAddr == {cadm_pkg::DIRECT_PAGE_HI, opByte1}
      && dstAddr == {cadm_pkg::DIRECT_PAGE_HI, opByte2};
  endproperty
  a_dirDir: assert property (p_dirDir) else $error("direct move addresses wrong");

  property p_immDir;
    @(posedge sys_clk) disable iff (sys_rst)
    addrMode == cadm_pkg::MODE_ID |-> immData == opByte1
      && dstAddr == {cadm_pkg::DIRECT_PAGE_HI, opByte2};
  endproperty
  a_immDir: assert property (p_immDir) else $error("immediate move wrong");

  property p_idxToDir;
    @(posedge sys_clk) disable iff (sys_rst)
    addrMode == cadm_pkg::MODE_XD |-> srcAddr == {indexHigh, indexLow}
      && dstAddr == {cadm_pkg::DIRECT_PAGE_HI, opByte1}
      && indexUpdate == addrStep;
  endproperty
  a_idxToDir: assert property (p_idxToDir) else $error("indexed to direct copy wrong");

  property p_dirToIdx;
    @(posedge sys_clk) disable iff (sys_rst)
    addrMode == cadm_pkg::MODE_DX |-> dstAddr == {indexHigh, indexLow}
      && srcAddr == {cadm_pkg::DIRECT_PAGE_HI, opByte1}
      && indexUpdate == addrStep;
  endproperty
  a_dirToIdx: assert property (p_dirToIdx) else $error("direct to indexed copy wrong");

  // Without debug enabled a halt in stop is refused and the CPU clock and oscillator stay off
  sequence s_stopHalt;
    state_r == STOPPED && isHalt && debugEn_r;
  endsequence
  property p_stopHalt;
    @(posedge sys_clk) disable iff (sys_rst)
    s_stopHalt |-> cmdExecute ##1 (inBackground && cpuClockOn);
  endproperty
  a_stopHalt: assert property (p_stopHalt) else $error("halt in stop ignored");

  property p_stopWake;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r == STOPPED && minClocksInStop && periodicWake) |-> minClockRun ##1 cpuClockOn;
  endproperty
  a_stopWake: assert property (p_stopWake) else $error("periodic wake from stop failed");

  property p_pinBoot;
    @(posedge sys_clk) disable iff (sys_rst)
    (inReset_r && !pinSync_r) |=> (inBackground && debugEnable);
  endproperty
  a_pinBoot: assert property (p_pinBoot) else $error("pin low at reset end ignored");

  property p_runCmd;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r == RUN && cmdValid && cmdKind inside {cadm_pkg::CMD_MEM, cadm_pkg::CMD_MEMSTAT,
      cadm_pkg::CMD_DBGREG, cadm_pkg::CMD_HALT}) |-> cmdAccept && cmdExecute;
  endproperty
  a_runCmd: assert property (p_runCmd) else $error("non-intrusive command refused in run");

endmodule
`default_nettype wire

// ==== rtl/cadm_pkg.sv ====
package cadm_pkg;
  // Addressing modes handled by the address generator
  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_IXW,
    MODE_SPB,
    MODE_SPW,
    MODE_DD,
    MODE_ID,
    MODE_XD,
    MODE_DX
  } cadm_mode_e;

  // Debug command classes from the serial front end
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_MEM,
    CMD_MEMSTAT,
    CMD_DBGREG,
    CMD_HALT,
    CMD_CPUREG,
    CMD_STEP,
    CMD_RESUME
  } cadm_cmd_e;

  localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam int unsigned STACK_PREBYTE_CYCLES = 1;
  localparam logic [7:0] ERR_STOP_WAIT = 8'h01;
endpackage

// ==== testbench/cadm_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module cadm_host (
  input wire logic inBackground,
  output logic cmdValid,
  output cadm_pkg::cadm_cmd_e cmdKind
);
  initial begin
    cmdValid = 1'b0;
    cmdKind = cadm_pkg::CMD_NONE;
  end
  // Active commands go out only in background unless a test is rude
  task automatic send(input cadm_pkg::cadm_cmd_e k, input logic rude);
    if (k < cadm_pkg::CMD_CPUREG || inBackground || rude) begin
      cmdKind = k;
      cmdValid = 1'b1;
    end
  endtask
  // A released bus shows junk, never the last command
  task automatic idle();
    cmdValid = 1'b0;
    cmdKind = cadm_pkg::cadm_cmd_e'(~cmdKind);
  endtask
endmodule
`default_nettype wire

// ==== testbench/cpu_address_and_debug_modes_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_address_and_debug_modes_bench;
  typedef struct {int sel; logic [15:0] v;} cadm_note_s;
  logic sys_clk, sys_rst, addrStep, indexUpdate, cmdValid, cmdAccept, cmdExecute, cmdError;
  logic waitOp, stopOp, haltOp, breakpointHit, irqPending, debugPin, hostAttached;
  logic debugEnableSet, minClocksInStop, periodicWake, clearIntMask, cpuClockOn;
  logic oscRun, minClockRun, inBackground, debugEnable;
  logic [7:0] opByte1, opByte2, indexHigh, indexLow, immData, cmdErrorCode;
  logic [15:0] stackPointer, srcAddr, dstAddr, indexNext, hx, dp1, dp2;
  logic [1:0] baseCycles;
  logic [2:0] busCycles;
  cadm_pkg::cadm_mode_e addrMode;
  cadm_pkg::cadm_cmd_e cmdKind;
  cadm_note_s notes[$];
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  integer seed = 32'hFB10;
  string sigName [0:15] = '{"srcAddr", "dstAddr", "immData", "indexNext", "indexUpdate",
    "busCycles", "cmdAccept", "cmdError", "cmdErrorCode", "clearIntMask", "cpuClockOn",
    "oscRun", "minClockRun", "inBackground", "debugEnable", "cmdExecute"};

  cadm_core u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .addrMode(addrMode),
    .addrStep(addrStep), .opByte1(opByte1), .opByte2(opByte2), .indexHigh(indexHigh),
    .indexLow(indexLow), .stackPointer(stackPointer), .baseCycles(baseCycles),
    .srcAddr(srcAddr), .dstAddr(dstAddr), .immData(immData), .indexNext(indexNext),
    .indexUpdate(indexUpdate), .busCycles(busCycles), .waitOp(waitOp), .stopOp(stopOp),
    .haltOp(haltOp), .breakpointHit(breakpointHit), .irqPending(irqPending),
    .debugPin(debugPin), .hostAttached(hostAttached), .debugEnableSet(debugEnableSet),
    .minClocksInStop(minClocksInStop), .periodicWake(periodicWake), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdAccept(cmdAccept), .cmdExecute(cmdExecute), .cmdError(cmdError),
    .cmdErrorCode(cmdErrorCode), .clearIntMask(clearIntMask), .cpuClockOn(cpuClockOn),
    .oscRun(oscRun), .minClockRun(minClockRun), .inBackground(inBackground),
    .debugEnable(debugEnable));
  cadm_host host (.inBackground(inBackground), .cmdValid(cmdValid), .cmdKind(cmdKind));

  function automatic logic [15:0] seen(input int s);
    logic [15:0] all [0:15];
    all = '{srcAddr, dstAddr, {8'h00, immData}, indexNext, {15'h0000, indexUpdate},
      {13'h0000, busCycles}, {15'h0000, cmdAccept}, {15'h0000, cmdError},
      {8'h00, cmdErrorCode}, {15'h0000, clearIntMask}, {15'h0000, cpuClockOn},
      {15'h0000, oscRun}, {15'h0000, minClockRun}, {15'h0000, inBackground},
      {15'h0000, debugEnable}, {15'h0000, cmdExecute}};
    return all[s];
  endfunction

  task automatic note(input int s, input logic [15:0] v);
    notes.push_back('{s, v});
  endtask

  task automatic cmpNote(input cadm_note_s n);
    logic [15:0] got;
    got = seen(n.sel);
    cmp_count++;
    if (got !== n.v) begin
      fails++;
      $display("ERROR %s expected %h seen %h", sigName[n.sel], n.v, got);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  // Accept and error are combinational, so they are noted in the cycle of the request
  task automatic cmd(input cadm_pkg::cadm_cmd_e k, input logic rude, acc, err);
    host.send(k, rude);
    note(6, {15'h0000, acc});
    note(7, {15'h0000, err});
    note(8, err ? {8'h00, cadm_pkg::ERR_STOP_WAIT} : 16'h0000);
    note(15, {15'h0000, acc && !err});
    tick(1);
    host.idle();
    // Idle cycle so the host never redrives the command in the step that released it
    tick(1);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Results are compared at the rising edge, before that edge's updates land
  always @(posedge sys_clk) begin
    while (notes.size() > 0) cmpNote(notes.pop_front());
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    sys_rst = 1'b1;
    {waitOp, stopOp, haltOp, breakpointHit, irqPending, debugEnableSet} = 6'h00;
    {minClocksInStop, periodicWake, addrStep, debugPin, hostAttached} = 5'h03;
    {opByte1, opByte2, indexHigh, indexLow, stackPointer} = 48'h0;
    baseCycles = 2'h0;
    addrMode = cadm_pkg::MODE_NONE;
    tick(6);
    sys_rst = 1'b0;
    tick(2);
    for (int i = 0; i < 70; i++) begin
      tick(1);
      {opByte1, opByte2, indexHigh, indexLow} = $random(seed);
      stackPointer = $random(seed);
      {baseCycles, addrStep} = $random(seed);
      // First pass of each mode hits the 16-bit wrap
      if (i < 7) {opByte1, opByte2, indexHigh, indexLow, stackPointer} = '1;
      addrMode = cadm_pkg::cadm_mode_e'(i % 7 + 1);
      hx = {indexHigh, indexLow};
      dp1 = {8'h00, opByte1};
      dp2 = {8'h00, opByte2};
      case (addrMode)
        cadm_pkg::MODE_IXW: note(0, hx + {opByte1, opByte2});
        cadm_pkg::MODE_SPB: note(0, stackPointer + dp1);
        cadm_pkg::MODE_SPW: note(0, stackPointer + {opByte1, opByte2});
        cadm_pkg::MODE_DD: begin
          note(0, dp1);
          note(1, dp2);
        end
        cadm_pkg::MODE_ID: begin
          note(2, dp1);
          note(1, dp2);
        end
        cadm_pkg::MODE_XD: begin
          note(0, hx);
          note(1, dp1);
        end
        default: begin
          note(0, dp1);
          note(1, hx);
        end
      endcase
      note(3, hx + 16'h0001);
      note(4, {15'h0000, addrStep && addrMode inside {cadm_pkg::MODE_XD, cadm_pkg::MODE_DX}});
      if (addrMode inside {cadm_pkg::MODE_SPB, cadm_pkg::MODE_SPW}) note(5, baseCycles + 16'h0001);
      if (addrMode == cadm_pkg::MODE_IXW) note(5, {14'h0000, baseCycles});
    end
    tick(1);
    cmd(cadm_pkg::CMD_CPUREG, 1'b1, 1'b0, 1'b0);
    cmd(cadm_pkg::CMD_MEM, 1'b0, 1'b1, 1'b0);
    pulse(haltOp);
    note(13, 16'h0001);
    cmd(cadm_pkg::CMD_CPUREG, 1'b0, 1'b1, 1'b0);
    cmd(cadm_pkg::CMD_DBGREG, 1'b0, 1'b1, 1'b0);
    cmd(cadm_pkg::CMD_RESUME, 1'b0, 1'b1, 1'b0);
    note(13, 16'h0000);
    waitOp = 1'b1;
    note(9, 16'h0001);
    tick(1);
    waitOp = 1'b0;
    note(10, 16'h0000);
    cmd(cadm_pkg::CMD_MEMSTAT, 1'b0, 1'b1, 1'b1);
    cmd(cadm_pkg::CMD_MEM, 1'b0, 1'b0, 1'b0);
    cmd(cadm_pkg::CMD_HALT, 1'b0, 1'b1, 1'b0);
    note(13, 16'h0001);
    note(10, 16'h0001);
    cmd(cadm_pkg::CMD_RESUME, 1'b0, 1'b1, 1'b0);
    pulse(waitOp);
    pulse(irqPending);
    note(10, 16'h0001);
    minClocksInStop = 1'b1;
    pulse(stopOp);
    note(12, 16'h0001);
    note(11, 16'h0000);
    cmd(cadm_pkg::CMD_HALT, 1'b0, 1'b0, 1'b0);
    pulse(periodicWake);
    note(10, 16'h0001);
    minClocksInStop = 1'b0;
    pulse(debugEnableSet);
    pulse(stopOp);
    note(11, 16'h0001);
    note(12, 16'h0000);
    note(10, 16'h0000);
    cmd(cadm_pkg::CMD_HALT, 1'b0, 1'b1, 1'b0);
    note(13, 16'h0001);
    cmd(cadm_pkg::CMD_RESUME, 1'b0, 1'b1, 1'b0);
    pulse(breakpointHit);
    note(13, 16'h0001);
    debugPin = 1'b0;
    sys_rst = 1'b1;
    tick(6);
    sys_rst = 1'b0;
    tick(2);
    note(13, 16'h0001);
    note(14, 16'h0001);
    tick(2);
    give_verdict();
  end
endmodule
`default_nettype wire
